//--- logic/csbpl_consts.svh
// constants of the card sideband pin logic
`ifndef CSBPL_CONSTS_SVH
`define CSBPL_CONSTS_SVH

`define CSBPL_CLK_HZ          20000000
`define CSBPL_WAKE_MIN_US     2000
`define CSBPL_WAKE_CYCLES     ((`CSBPL_WAKE_MIN_US * (`CSBPL_CLK_HZ / 1000000)))
`define CSBPL_WAKE_CNT_W      16
`define CSBPL_CYL_MAX         16'h3FFF
`define CSBPL_CYL_W           16
`define CSBPL_HEAD_W          4
`define CSBPL_SECT_W          8

`endif

//--- logic/csbpl_pkg.sv
// types of the card sideband pin logic
package csbpl_pkg;

  typedef enum logic [1:0] {
    CSBPL_LINK_UP,
    CSBPL_SLUMBER,
    CSBPL_DEEP_SLEEP,
    CSBPL_WAKING
  } csbpl_pwr_t;

endpackage

//--- logic/csbpl_sync.sv
// two-stage synchroniser for one level input
`timescale 1ns/1ps

module csbpl_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic meta;
    logic sync;
  } csbpl_sync_st_t;

  csbpl_sync_st_t state_reg;
  csbpl_sync_st_t state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.meta = d;
    // first stage feeds only the second
    state_next.sync = state_reg.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.sync;

endmodule

//--- logic/csbpl_top.sv
// sideband pin logic of the removable card: indicators, write protect, presence/deep sleep, chs limit
//
// Notes on behaviour
// R1 - activity indicator driven low while a command runs, released when idle.
// R2 - link indicator driven low while the serial link is connected and active.
// R3 - indicators only ever drive low; otherwise released to weak pull-up.
// R4 - write protect pin low: every write command is rejected.
// R5 - presence pins never driven by the card, only sensed.
// R6 - host may tie presence input low and sense output through its pull-up.
// R7 - chs addressing capped at 16383 cylinders; larger capacity needs lba.
// R8 - host may ask for deep sleep only while the link sits in slumber.
// R9 - host holds presence input low normally, drives it high for deep sleep.
// R10 - presence input low pulses under 2 ms are ignored during deep sleep.
// R11 - after leaving deep sleep into slumber, the card sends a wake signal.
// R12 - write protect and presence inputs pass a two-stage synchroniser first.
`timescale 1ns/1ps
`include "csbpl_consts.svh"

module csbpl_top
  import csbpl_pkg::*;
(
  input  wire logic                       CLK,
  input  wire logic                       RESET_N,
  input  wire logic                       CMD_START,
  input  wire logic                       CMD_IS_WRITE,
  input  wire logic                       CMD_DONE,
  input  wire logic                       LINK_ACTIVE,
  input  wire logic                       LINK_IN_SLUMBER,
  input  wire logic                       PHY_READY,
  input  wire logic                       WRITE_PROTECT_PIN_N,
  input  wire logic                       PRESENCE_SENSE_IN,
  input  wire logic [`CSBPL_CYL_W-1:0]    CHS_CYL_IN,
  input  wire logic [`CSBPL_HEAD_W-1:0]   CHS_HEAD_IN,
  input  wire logic [`CSBPL_SECT_W-1:0]   CHS_SECT_IN,
  input  wire logic                       CHS_CHECK,
  output logic                            ACTIVITY_INDICATOR_OUT,
  output logic                            ACTIVITY_INDICATOR_OE,
  output logic                            LINK_INDICATOR_OUT,
  output logic                            LINK_INDICATOR_OE,
  output logic                            PRESENCE_SENSE_OE,
  output logic                            CMD_ACCEPT,
  output logic                            CMD_REJECT,
  output logic                            CHS_REJECT,
  output logic                            PHY_DEEP_SLEEP,
  output logic                            PHY_POWER_UP,
  output logic                            WAKE_SEND
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // asserts at once, releases on the clock, so no flop sees release near its edge
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic wp_active;
  logic wp_sync;
  logic presence_sync;

  // protect enters active high, so the synchroniser's reset value reads as unprotected
  // and a write right after reset is not refused by a stale low
  assign wp_active = !WRITE_PROTECT_PIN_N;

  csbpl_sync u_sync_wp (                                                      // R12
    .clk   (CLK),
    .rst_n (rst_n_reg),
    .d     (wp_active),
    .q     (wp_sync)
  );

  csbpl_sync u_sync_presence (                                                // R12
    .clk   (CLK),
    .rst_n (rst_n_reg),
    .d     (PRESENCE_SENSE_IN),
    .q     (presence_sync)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    csbpl_pwr_t                    pwr;
    logic [`CSBPL_WAKE_CNT_W-1:0]  low_cnt;
    logic                          busy;
    logic                          act_oe;
    logic                          link_oe;
    logic                          accept;
    logic                          reject;
    logic                          chs_reject;
    logic                          deep_sleep;
    logic                          phy_up;
    logic                          wake;
  } csbpl_state_t;

  csbpl_state_t state_reg;
  csbpl_state_t state_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // the count fits 16 bits at this clock; a faster clock needs a wider counter
  localparam logic [`CSBPL_WAKE_CNT_W-1:0] WAKE_CYCLES = `CSBPL_WAKE_CNT_W'(`CSBPL_WAKE_CYCLES);

  function automatic logic chs_in_range(input logic [`CSBPL_CYL_W-1:0] cyl);
    chs_in_range = (cyl <= `CSBPL_CYL_MAX);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next            = state_reg;
    state_next.accept     = 1'b0;
    state_next.reject     = 1'b0;
    state_next.chs_reject = 1'b0;
    state_next.wake       = 1'b0;

    // write protect sampled at command start; a rejected write never goes busy
    // a done in the same cycle as a start is dropped: the new command keeps the lamp on
    if (CMD_START) begin
      if (CMD_IS_WRITE && wp_sync) begin
        state_next.reject = 1'b1;                                             // R4
      end else begin
        state_next.accept = 1'b1;
        state_next.busy   = 1'b1;
      end
    end else if (CMD_DONE) begin
      state_next.busy = 1'b0;
    end

    // cylinders beyond the cap cannot be reached in chs mode
    if (CHS_CHECK && !chs_in_range(CHS_CYL_IN)) begin
      state_next.chs_reject = 1'b1;                                           // R7
    end

    state_next.act_oe  = state_next.busy;                                    // R1
    // slumber and deep sleep count as not active, so the link lamp goes out
    state_next.link_oe = LINK_ACTIVE && (state_reg.pwr == CSBPL_LINK_UP);    // R2

    // all four codes of the power state are used, so no default
    unique case (state_reg.pwr)
      CSBPL_LINK_UP: begin
        // the filter starts from zero on every entry to deep sleep
        state_next.low_cnt = '0;
        if (LINK_IN_SLUMBER) begin
          state_next.pwr = CSBPL_SLUMBER;
        end
      end
      CSBPL_SLUMBER: begin
        // deep sleep is only honoured from slumber
        if (!LINK_IN_SLUMBER) begin
          state_next.pwr = CSBPL_LINK_UP;
        end else if (presence_sync) begin
          state_next.pwr        = CSBPL_DEEP_SLEEP;                           // R8
          state_next.deep_sleep = 1'b1;
          state_next.low_cnt    = '0;
        end
      end
      CSBPL_DEEP_SLEEP: begin
        // short presence probes restart the count when the input rises again
        if (presence_sync) begin
          state_next.low_cnt = '0;
        end else if (state_reg.low_cnt >= WAKE_CYCLES - 1'b1) begin
          state_next.pwr        = CSBPL_WAKING;                               // R10
          state_next.deep_sleep = 1'b0;
          state_next.phy_up     = 1'b1;
        end else begin
          state_next.low_cnt = state_reg.low_cnt + 1'b1;                      // R10
        end
      end
      CSBPL_WAKING: begin
        // power-up request holds until the phy reports it is back in slumber
        if (PHY_READY) begin
          state_next.wake   = 1'b1;                                           // R11
          state_next.phy_up = 1'b0;
          state_next.pwr    = CSBPL_SLUMBER;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // indicators drive only low, so a host tying them low sees no contention
  assign ACTIVITY_INDICATOR_OUT = 1'b0;                                       // R3
  assign ACTIVITY_INDICATOR_OE  = state_reg.act_oe;
  assign LINK_INDICATOR_OUT     = 1'b0;                                       // R3
  assign LINK_INDICATOR_OE      = state_reg.link_oe;
  // presence pins are sense only; the host's pull-up or driver sets their level
  assign PRESENCE_SENSE_OE      = 1'b0;                                       // R5

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  assign CMD_ACCEPT             = state_reg.accept;
  assign CMD_REJECT             = state_reg.reject;
  assign CHS_REJECT             = state_reg.chs_reject;
  assign PHY_DEEP_SLEEP         = state_reg.deep_sleep;
  assign PHY_POWER_UP           = state_reg.phy_up;
  assign WAKE_SEND              = state_reg.wake;

endmodule

//--- verification/csbpl_sva.sv
// port assertions of the card sideband pin logic
`timescale 1ns/1ps
`include "csbpl_consts.svh"

module csbpl_sva (
  input wire logic                    CLK,
  input wire logic                    RESET_N,
  input wire logic                    CMD_START,
  input wire logic                    CMD_IS_WRITE,
  input wire logic                    CMD_DONE,
  input wire logic                    LINK_ACTIVE,
  input wire logic                    PHY_READY,
  input wire logic                    WRITE_PROTECT_PIN_N,
  input wire logic                    PRESENCE_SENSE_IN,
  input wire logic                    CHS_CHECK,
  input wire logic                    ACTIVITY_INDICATOR_OUT,
  input wire logic                    ACTIVITY_INDICATOR_OE,
  input wire logic                    LINK_INDICATOR_OUT,
  input wire logic                    LINK_INDICATOR_OE,
  input wire logic                    PRESENCE_SENSE_OE,
  input wire logic                    CMD_ACCEPT,
  input wire logic                    CMD_REJECT,
  input wire logic                    CHS_REJECT,
  input wire logic                    PHY_DEEP_SLEEP,
  input wire logic                    PHY_POWER_UP,
  input wire logic                    WAKE_SEND,
  input wire logic [`CSBPL_CYL_W-1:0] CHS_CYL_IN
);
  int low_cnt_reg;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // raw low run of the presence pin, so the 2 ms filter can be judged
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
      low_cnt_reg <= 0;
    else
      low_cnt_reg <= PRESENCE_SENSE_IN ? 0 : low_cnt_reg + 1;
  AST_IND_LOW: assert property (!ACTIVITY_INDICATOR_OUT && !LINK_INDICATOR_OUT) else $error("ind hi");
  AST_PRES_OE: assert property (!PRESENCE_SENSE_OE) else $error("presence driven");
  AST_ACT_ON: assert property (CMD_START && !CMD_IS_WRITE |=> CMD_ACCEPT && ACTIVITY_INDICATOR_OE)
    else $error("read not taken");
  AST_ACT_OFF: assert property (CMD_DONE && !CMD_START |=> !ACTIVITY_INDICATOR_OE) else $error("busy");
  AST_WP: assert property ((!WRITE_PROTECT_PIN_N)[*3] ##0 (CMD_START && CMD_IS_WRITE) |=> CMD_REJECT && !CMD_ACCEPT)
    else $error("write not refused");
  AST_CHS: assert property (CHS_CHECK |=> CHS_REJECT == ($past(CHS_CYL_IN) > `CSBPL_CYL_MAX)) else $error("chs");
  AST_LINK: assert property (LINK_INDICATOR_OE |-> $past(LINK_ACTIVE)) else $error("link ind");
  AST_EXIT: assert property ($fell(PHY_DEEP_SLEEP) |-> PHY_POWER_UP && low_cnt_reg >= `CSBPL_WAKE_CYCLES)
    else $error("early exit");
  AST_WAKE: assert property (WAKE_SEND |-> $past(PHY_POWER_UP) && $past(PHY_READY) ##1 !WAKE_SEND)
    else $error("wake");
endmodule

//--- verification/csbpl_host.sv
// host controller model of the joined presence pins
`timescale 1ns/1ps

module csbpl_host (
  input  wire logic clk,
  input  wire logic in_slumber,
  input  wire logic pres_oe,
  output logic      pres_in
);
  logic drv_reg = 1'h0;
  // card never drives, so the host output sets both joined pins
  assign pres_in = pres_oe ? 1'h0 : drv_reg;
  task automatic drive(input logic v, input int n);
    if (v && !in_slumber)
      return;
    drv_reg = v;
    repeat (n) @(negedge clk);
  endtask
endmodule

//--- verification/tb_top.sv
// self-checking bench of the card sideband pin logic
`timescale 1ns/1ps
`include "csbpl_consts.svh"

module tb_top;
  logic CLK = 0, RESET_N = 0, CMD_START = 0, CMD_IS_WRITE = 0, CMD_DONE = 0, LINK_ACTIVE = 0;
  logic LINK_IN_SLUMBER = 0, PHY_READY = 0, WRITE_PROTECT_PIN_N = 1, CHS_CHECK = 0;
  logic [15:0] CHS_CYL_IN = 16'h0000;
  logic [3:0] CHS_HEAD_IN = 4'h0;
  logic [7:0] CHS_SECT_IN = 8'h00;
  logic PRESENCE_SENSE_IN, ACTIVITY_INDICATOR_OUT, ACTIVITY_INDICATOR_OE, LINK_INDICATOR_OUT, LINK_INDICATOR_OE;
  logic PRESENCE_SENSE_OE, CMD_ACCEPT, CMD_REJECT, CHS_REJECT, PHY_DEEP_SLEEP, PHY_POWER_UP, WAKE_SEND;
  int miscompares = 0, checked = 0, cycles = 0;
  csbpl_top uut (.*);
  csbpl_host host (.clk(CLK), .in_slumber(LINK_IN_SLUMBER), .pres_oe(PRESENCE_SENSE_OE), .pres_in(PRESENCE_SENSE_IN));
  always #25 CLK = ~CLK;
  // two runs of the 2 ms wake filter take about 80000 cycles; the rest is a few dozen
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic cmd(input logic st, input logic wr, input logic dn);
    CMD_START = st;
    CMD_IS_WRITE = wr;
    CMD_DONE = dn;
    @(negedge CLK);
  endtask
  task automatic t_cmd();
    cmd(1'h1, 1'h0, 1'h0);
    cmp(ACTIVITY_INDICATOR_OE ? ACTIVITY_INDICATOR_OUT : 1'h1, 1'h0, "act pin");
    cmd(1'h1, 1'h1, 1'h1);
    cmp({CMD_ACCEPT, ACTIVITY_INDICATOR_OE}, 2'h3, "start wins");
    cmd(1'h0, 1'h0, 1'h1);
    cmp(ACTIVITY_INDICATOR_OE, 1'h0, "idle");
    cmd(1'h0, 1'h0, 1'h0);
    $display("cmd test ends");
  endtask
  task automatic t_wp();
    WRITE_PROTECT_PIN_N = 1'h0;
    repeat (3) @(negedge CLK);
    cmd(1'h1, 1'h1, 1'h0);
    cmp({CMD_REJECT, CMD_ACCEPT, ACTIVITY_INDICATOR_OE}, 3'h4, "wp write");
    cmd(1'h1, 1'h0, 1'h0);
    cmp(CMD_ACCEPT, 1'h1, "wp read");
    cmd(1'h0, 1'h0, 1'h1);
    cmd(1'h0, 1'h0, 1'h0);
    WRITE_PROTECT_PIN_N = 1'h1;
    $display("wp test ends");
  endtask
  task automatic t_chs();
    logic [15:0] cyl[4] = '{16'h3FFF, 16'h4000, 16'hFFFF, 16'h0000};
    foreach (cyl[i]) begin
      CHS_CYL_IN = cyl[i];
      CHS_CHECK = 1'h1;
      @(negedge CLK);
      cmp(CHS_REJECT, cyl[i] > `CSBPL_CYL_MAX, "chs");
    end
    CHS_CHECK = 1'h0;
    $display("chs test ends");
  endtask
  task automatic t_link();
    LINK_ACTIVE = 1'h1;
    repeat (2) @(negedge CLK);
    cmp(LINK_INDICATOR_OE ? LINK_INDICATOR_OUT : 1'h1, 1'h0, "link pin");
    LINK_ACTIVE = 1'h0;
    repeat (2) @(negedge CLK);
    cmp(LINK_INDICATOR_OE, 1'h0, "link off");
    $display("link test ends");
  endtask
  task automatic t_sleep();
    LINK_IN_SLUMBER = 1'h1;
    repeat (2) @(negedge CLK);
    host.drive(1'h1, 6);
    cmp(PHY_DEEP_SLEEP, 1'h1, "sleep in");
    cmp(PRESENCE_SENSE_OE, 1'h0, "presence driven");
    // one low cycle short of the filter must be ignored
    host.drive(1'h0, `CSBPL_WAKE_CYCLES - 1);
    host.drive(1'h1, 6);
    cmp({PHY_DEEP_SLEEP, PHY_POWER_UP}, 2'h2, "short low");
    // two cycles of synchroniser delay: the last low sample lands one edge later
    host.drive(1'h0, `CSBPL_WAKE_CYCLES + 1);
    cmp({PHY_DEEP_SLEEP, PHY_POWER_UP}, 2'h2, "low one short");
    @(negedge CLK);
    cmp({PHY_DEEP_SLEEP, PHY_POWER_UP}, 2'h1, "long low");
    PHY_READY = 1'h1;
    for (int i = 0; i < 8 && WAKE_SEND !== 1'h1; i++) @(negedge CLK);
    cmp(WAKE_SEND, 1'h1, "wake");
    PHY_READY = 1'h0;
    repeat (2) @(negedge CLK);
    cmp(PHY_POWER_UP, 1'h0, "phy up");
    LINK_IN_SLUMBER = 1'h0;
    $display("sleep test ends");
  endtask
  initial begin
    repeat (5) @(negedge CLK);
    RESET_N = 1'h1;
    repeat (4) @(negedge CLK);
    t_cmd();
    t_wp();
    t_chs();
    t_link();
    t_sleep();
    close_out();
  end
endmodule

bind csbpl_top csbpl_sva chk (.*);
